// ==== lsr_assertions.sv ====
`timescale 1ns/1ps
`include "lsr_params.svh"
module lsr_checker #(
    parameter int NCH = 4
)(
    input wire logic           clock,
    input wire logic           reset_n,
    input wire logic [6:0]     reg_addr,
    input wire logic           reg_wr,
    input wire logic           reg_rd,
    input wire logic [15:0]    reg_wdata,
    input wire logic [15:0]    reg_rdata,
    input wire logic           reg_rvalid,
    input wire logic           conv_done,
    input wire logic           continuous_mode,
    input wire logic [NCH-1:0] chan_fault_raw,
    input wire logic           adc_ready_n,
    input wire logic [NCH-1:0] chan_fault_live
);
    // counts low cycles in continuous mode only, restarted by each done pulse
    logic [11:0] low_r;
    logic [11:0] low_nxt;
    wire         clr_wr;
    assign clr_wr = reg_wr && reg_addr == `LSR_ADDR && reg_wdata[14];
    assign low_nxt = !continuous_mode ? 12'h000 :
                     conv_done ? 12'h001 :
                     (adc_ready_n ? 12'h000 : low_r + 12'h001);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) low_r <= 12'h000;
        else low_r <= low_nxt;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr != `LSR_ADDR |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (
        reg_rvalid |-> !reg_rdata[15]) else $error("bit 15 set");
    a_ready_falls: assert property (conv_done |=> !adc_ready_n)
        else $error("ready pin did not fall");
    a_single_hold: assert property (
        !continuous_mode && !$past(continuous_mode) && !adc_ready_n &&
        !clr_wr |=> !adc_ready_n)
        else $error("ready pin rose without clear");
    a_single_clear: assert property (
        !continuous_mode && clr_wr && !conv_done |=> adc_ready_n)
        else $error("ready pin stayed low after clear");
    a_cont_width: assert property (
        continuous_mode && $past(continuous_mode) &&
        $past(continuous_mode, 2) && $rose(adc_ready_n) |-> low_r == 12'h961)
        else $error("continuous pulse width wrong");
    a_cont_bound: assert property (
        continuous_mode |-> low_r <= 12'h961)
        else $error("continuous pulse too long");
    a_fault_fall: assert property (
        (chan_fault_live & ~$past(chan_fault_raw)) == '0)
        else $error("channel fault held without cause");
endmodule
bind lsr_top lsr_checker #(.NCH(NCH)) lsr_checker_inst (.*);

// ==== lsr_debounce.sv ====
`timescale 1ns/1ps
module lsr_debounce
    import lsr_pkg::*;
#(
    parameter int          NCH         = 4,
    parameter int unsigned DEB_CYCLES  = 200000
)(
    input  wire logic      clock,
    input  wire logic      reset_n,
    lsr_if.filter          flt
);
    localparam int CW = $clog2(DEB_CYCLES + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(DEB_CYCLES - 1);

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [CW-1:0] cnt_r;
            logic [CW-1:0] cnt_nxt;
            logic          deb_r;
            logic          deb_nxt;
            wire           at_max = (cnt_r == CNT_MAX);

            // a fault must stay present the whole window
            assign cnt_nxt = !flt.fault_raw[g] ? '0 :
                             at_max ? cnt_r : cnt_r + CW'(1);
            // input-function faults arrive already filtered upstream
            assign deb_nxt = !flt.needs_debounce[g] ? flt.fault_raw[g] :
                             (flt.fault_raw[g] & (at_max | deb_r));

            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    cnt_r <= '0;
                    deb_r <= 1'h0;
                end else begin
                    cnt_r <= cnt_nxt;
                    deb_r <= deb_nxt;
                end
            end
            assign flt.fault_debounced[g] = deb_r;
        end
    endgenerate
endmodule

// ==== lsr_if.sv ====
`timescale 1ns/1ps
interface lsr_if #(
    parameter int NCH = 4
);
    logic [NCH-1:0] fault_raw;
    logic [NCH-1:0] needs_debounce;
    logic [NCH-1:0] fault_debounced;

    modport owner (
        output fault_raw,
        output needs_debounce,
        input  fault_debounced
    );
    modport filter (
        input  fault_raw,
        input  needs_debounce,
        output fault_debounced
    );
endinterface

// ==== lsr_params.svh ====
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH

`define LSR_ADDR            7'h2F
`define LSR_RESET           16'h0000
`define LSR_BIT_RESERVED    15
`define LSR_BIT_DATA_RDY    14
`define LSR_BIT_BUSY        13
`define LSR_SRC_HI          12
`define LSR_SRC_LO          10
`define LSR_SUP_HI          9
`define LSR_SUP_LO          5
`define LSR_BIT_OVERTEMP    4
`define LSR_CHAN_HI         3
`define LSR_CHAN_LO         0

`define LSR_CLK_PERIOD_NS   10
`define LSR_RDY_PULSE_US    24
`define LSR_RDY_PULSE_CYC   ((`LSR_RDY_PULSE_US * 1000) / `LSR_CLK_PERIOD_NS)
`define LSR_DEB_MS          2
`define LSR_DEB_CYC         ((`LSR_DEB_MS * 1000000) / `LSR_CLK_PERIOD_NS)

`endif

// ==== lsr_pkg.sv ====
package lsr_pkg;
    typedef enum logic [0:0] {
        rdy_idle,
        rdy_low
    } lsr_rdy_state_t;

    typedef logic [2:0]  lsr_src_code_t;
    typedef logic [15:0] lsr_word_t;
endpackage

// ==== lsr_top.sv ====
`timescale 1ns/1ps
`include "lsr_params.svh"
module lsr_top
    import lsr_pkg::*;
#(
    parameter int          NCH        = 4,
    parameter int unsigned DEB_CYCLES = `LSR_DEB_CYC
)(
    input  wire logic           clock,
    input  wire logic           reset_n,
    input  wire logic [6:0]     reg_addr,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    input  wire logic [15:0]    reg_wdata,
    output logic      [15:0]    reg_rdata,
    output logic                reg_rvalid,
    input  wire logic           conv_done,
    input  wire logic           conv_busy,
    input  wire logic           conv_is_diag,
    input  wire logic [1:0]     conv_index,
    input  wire logic           continuous_mode,
    input  wire logic           overtemp_detect,
    input  wire logic [4:0]     supply_fault,
    input  wire logic [NCH-1:0] chan_fault_raw,
    input  wire logic [NCH-1:0] chan_needs_debounce,
    output logic                adc_ready_n,
    output logic      [NCH-1:0] chan_fault_live
);
    localparam int PW = 12;
    localparam logic [PW-1:0] PULSE_LAST = PW'(`LSR_RDY_PULSE_CYC - 1);

    lsr_if #(.NCH(NCH)) flt_if ();

    logic           data_rdy_r;
    logic           data_rdy_nxt;
    logic           busy_r;
    lsr_src_code_t  src_r;
    lsr_src_code_t  src_nxt;
    logic [4:0]     sup_r;
    logic           hot_r;
    lsr_word_t      rdata_r;
    lsr_word_t      rdata_nxt;
    logic           rvalid_r;
    lsr_rdy_state_t rdy_state_r;
    lsr_rdy_state_t rdy_state_nxt;
    logic [PW-1:0]  pulse_cnt_r;
    logic [PW-1:0]  pulse_cnt_nxt;
    logic           ready_n_r;
    logic           ready_n_nxt;
    lsr_word_t      live_word;

    wire addr_hit  = (reg_addr == `LSR_ADDR);
    wire clear_hit = reg_wr & addr_hit & reg_wdata[`LSR_BIT_DATA_RDY];

    assign flt_if.fault_raw      = chan_fault_raw;
    assign flt_if.needs_debounce = chan_needs_debounce;

    lsr_debounce #(
        .NCH        (NCH),
        .DEB_CYCLES (DEB_CYCLES)
    ) u_deb (
        .clock   (clock),
        .reset_n (reset_n),
        .flt     (flt_if.filter)
    );

    // diag flag on top, index below, so channel D lands on 011
    assign src_nxt = {conv_is_diag, conv_index};

    // a new completion in the clearing cycle wins over the clear
    assign data_rdy_nxt = conv_done | (data_rdy_r & ~clear_hit);

    // only bit 14 is writable; everything else ignores writes
    assign live_word = {
        1'h0,
        data_rdy_r,
        busy_r,
        src_r,
        sup_r,
        hot_r,
        flt_if.fault_debounced
    };

    // unmapped addresses read back zero
    assign rdata_nxt = addr_hit ? live_word : '0;

    always_comb begin
        rdy_state_nxt = rdy_state_r;
        pulse_cnt_nxt = pulse_cnt_r;
        case (rdy_state_r)
            rdy_idle: begin
                if (continuous_mode && conv_done) begin
                    rdy_state_nxt = rdy_low;
                    pulse_cnt_nxt = '0;
                end
            end
            rdy_low: begin
                if (!continuous_mode) begin
                    rdy_state_nxt = rdy_idle;
                end else if (conv_done) begin
                    pulse_cnt_nxt = '0;
                end else if (pulse_cnt_r == PULSE_LAST) begin
                    rdy_state_nxt = rdy_idle;
                end else begin
                    pulse_cnt_nxt = pulse_cnt_r + PW'(1);
                end
            end
            default: begin
                rdy_state_nxt = rdy_idle;
                pulse_cnt_nxt = '0;
            end
        endcase
    end

    // pin is low while asserted; fixed width pulse ignores the flag
    assign ready_n_nxt = continuous_mode ? (rdy_state_nxt != rdy_low)
                                         : ~data_rdy_nxt;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_rdy_r <= 1'h0;
            busy_r     <= 1'h0;
            src_r      <= '0;
            sup_r      <= '0;
            hot_r      <= 1'h0;
        end else begin
            data_rdy_r <= data_rdy_nxt;
            busy_r     <= conv_busy;
            src_r      <= src_nxt;
            sup_r      <= supply_fault;
            hot_r      <= overtemp_detect;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r  <= `LSR_RESET;
            rvalid_r <= 1'h0;
        end else begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdy_state_r <= rdy_idle;
            pulse_cnt_r <= '0;
            ready_n_r   <= 1'h1;
        end else begin
            rdy_state_r <= rdy_state_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            ready_n_r   <= ready_n_nxt;
        end
    end

    assign reg_rdata       = rdata_r;
    assign reg_rvalid      = rvalid_r;
    assign adc_ready_n     = ready_n_r;
    assign chan_fault_live = flt_if.fault_debounced;
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "lsr_params.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
    import lsr_pkg::*;
    logic       clock = '0, reset_n = '0, reg_wr = '0, reg_rd = '0;
    logic       conv_done = '0, conv_busy = '0, conv_is_diag = '0;
    logic       continuous_mode = '0, overtemp_detect = '0;
    logic       reg_rvalid, adc_ready_n;
    logic [1:0] conv_index = '0;
    logic [6:0] reg_addr = '0;
    logic [4:0] supply_fault = '0;
    logic [3:0] chan_fault_raw = '0, chan_needs_debounce = '0;
    logic [3:0] chan_fault_live;
    lsr_word_t  reg_wdata = '0, reg_rdata, d, exp_w;
    int         errors = 0, total_checks = 0, n;
    // short debounce keeps the run brief
    localparam int DEB = 20;
    lsr_top #(.DEB_CYCLES(DEB)) lsr_top_inst (.*);
    initial forever #5 clock = ~clock;
    task step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task rd(input logic [6:0] a);
        reg_rd = 1'h1;
        reg_addr = a;
        step(1);
        reg_rd = 1'h0;
        d = reg_rdata;
        `CHK("rvalid", 1'h1, reg_rvalid)
        step(1);
        `CHK("rvalid low", 1'h0, reg_rvalid)
    endtask
    task wr(input lsr_word_t w);
        reg_wr = 1'h1;
        reg_addr = `LSR_ADDR;
        reg_wdata = w;
        step(1);
        reg_wr = 1'h0;
        step(1);
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task t_reg;
        rd(`LSR_ADDR);
        `CHK("reset", 16'h0000, d)
        wr(16'hFFFF);
        rd(`LSR_ADDR);
        `CHK("ro", 16'h0000, d)
        overtemp_detect = 1'h1;
        step(1);
        rd(7'h30);
        `CHK("unmapped", 16'h0000, d)
        overtemp_detect = 1'h0;
        step(1);
        $display("t_reg done");
    endtask
    task t_live;
        for (int i = 0; i < 8; i++) begin
            {conv_is_diag, conv_index} = i[2:0];
            conv_busy = ~i[0];
            overtemp_detect = i[1];
            supply_fault = 5'h01 << (i % 5);
            step(2);
            rd(`LSR_ADDR);
            exp_w = {2'h0, ~i[0], i[2:0], supply_fault, i[1], 4'h0};
            `CHK("live", exp_w, d)
        end
        {conv_busy, conv_is_diag, conv_index, overtemp_detect} = '0;
        supply_fault = '0;
        step(2);
        $display("t_live done");
    endtask
    task t_single;
        conv_done = 1'h1;
        step(1);
        conv_done = 1'h0;
        `CHK("pin", 1'h0, adc_ready_n)
        wr(16'hBFFF);
        rd(`LSR_ADDR);
        `CHK("flag", 16'h4000, d)
        `CHK("pin", 1'h0, adc_ready_n)
        wr(16'h4000);
        rd(`LSR_ADDR);
        `CHK("flag", 16'h0000, d)
        `CHK("pin", 1'h1, adc_ready_n)
        $display("t_single done");
    endtask
    task t_cont;
        continuous_mode = 1'h1;
        conv_done = 1'h1;
        step(1);
        conv_done = 1'h0;
        n = 0;
        while (adc_ready_n === 1'h0 && n < 3000) begin
            n++;
            step(1);
        end
        `CHK("pulse", 2400, n)
        if (n >= 3000) results;
        rd(`LSR_ADDR);
        `CHK("flag", 16'h4000, d)
        wr(16'h4000);
        continuous_mode = 1'h0;
        $display("t_cont done");
    endtask
    task t_chan;
        chan_fault_raw = 4'h5;
        step(2);
        rd(`LSR_ADDR);
        `CHK("chan", 16'h0005, d)
        chan_fault_raw = 4'hF;
        chan_needs_debounce = 4'hF;
        step(DEB - 1);
        `CHK("deb", 4'h5, chan_fault_live)
        step(1);
        `CHK("deb", 4'hF, chan_fault_live)
        chan_fault_raw = 4'h0;
        step(2);
        `CHK("fall", 4'h0, chan_fault_live)
        $display("t_chan done");
    endtask
    initial begin
        step(2);
        reset_n = 1'h1;
        step(1);
        t_reg;
        t_live;
        t_single;
        t_cont;
        t_chan;
        results;
    end
endmodule
